// file: flash_seq_pkg.sv
// Purpose: constants and types of the flash programming sequencer
// Assumes: 32-bit classic Wishbone, word index = byte address / 4
// Notes: monitor registers keep their printed offsets as word indices
//
// How it works
// - boot flag 0 alternate area, 1 default
// - boot flag blank 1, loaded from low word
// - monitor bits 7..0,15 read 0; 14..9 one
// - window start monitor from low word bits
// - window end monitor from high word bits
// - 32-byte identifier only via ID read command
// - default blocks 0-15, alternate blocks 16-31
// - boot protection only with 32 KB or more code
// - outside window program/erase is refused
// - window covers code user area only
// - window enforced only in self-programming
// - reset enters data-flash access disabled mode
// - enable bit moves to combined read mode
// - code read answered within one cycle, except in code PE mode
// - 08h and entries cleared returns read
// - code entry with 82h or C2h
// - data entry with 10h or 50h
// - four modes, changed only by three registers
// - program writes 4 bytes code, 1 data
// - blank check reports no programmed data
// - config programs update boot and window
// - block erase and identifier read commands
// - window violation sets illegal command flag
package flash_seq_pkg;
   // ****************************************************
   // register word indices
   // ****************************************************
   localparam logic [29:0] IDX_DF_CTRL = 30'h0000000; // dataflash_control
   localparam logic [29:0] IDX_ENTRY = 30'h0000001; // pe_entry_register
   localparam logic [29:0] IDX_PMC = 30'h0000002; // pe_mode_control
   localparam logic [29:0] IDX_CMD = 30'h0000003; // command start
   localparam logic [29:0] IDX_ADDR = 30'h0000004; // target address
   localparam logic [29:0] IDX_WDATA = 30'h0000005; // program data
   localparam logic [29:0] IDX_CFG_LOW = 30'h0000006; // config_word_low
   localparam logic [29:0] IDX_CFG_HIGH = 30'h0000007; // config_word_high
   localparam logic [29:0] IDX_STATUS = 30'h0000008; // status
   localparam logic [29:0] IDX_UID = 30'h0000010; // identifier words 0..7
   localparam logic [29:0] IDX_BOOT_MON = 30'h07FC0B0; // startup_setting_monitor
   localparam logic [29:0] IDX_WSTART_MON = 30'h07FC0B2; // window_start_monitor
   localparam logic [29:0] IDX_WEND_MON = 30'h07FC0B4; // window_end_monitor
   // ****************************************************
   // field layout and values
   // ****************************************************
   localparam int DF_BIT = 19; // address bit that selects data flash
   localparam int BLK_LSB = 10; // block size 1 KB
   localparam int BOOT_BIT = 8; // boot select bit of low word
   localparam int CODE_KBYTES = 32; // code flash size of this variant
   localparam logic [7:0] PMC_READ = 8'h08;
   localparam logic [7:0] PMC_CODE_A = 8'h82;
   localparam logic [7:0] PMC_CODE_B = 8'hC2;
   localparam logic [7:0] PMC_DATA_A = 8'h10;
   localparam logic [7:0] PMC_DATA_B = 8'h50;
   localparam logic BLANK_BOOT = 1'b1; // blank part boots default area
   localparam logic [9:0] BLANK_WIN = 10'h3FF; // blank window bound
   localparam logic [6:0] BOOT_MON_HIGH = 7'h3F; // bits 15..9 of monitor
   localparam logic [19:0] UID_ADDR = 20'h00850; // identifier in extra area
   localparam logic [2:0] UID_LAST = 3'h7; // eight words of identifier
   localparam logic [2:0] BYTES_CODE = 3'h4;
   localparam logic [2:0] BYTES_DATA = 3'h1;
   // ****************************************************
   // commands, flash operations, modes
   // ****************************************************
   localparam logic [3:0] CMD_PROG = 4'h1;
   localparam logic [3:0] CMD_ERASE = 4'h2;
   localparam logic [3:0] CMD_BLANK = 4'h3;
   localparam logic [3:0] CMD_BOOT_PROG = 4'h4;
   localparam logic [3:0] CMD_WIN_PROG = 4'h5;
   localparam logic [3:0] CMD_UID_READ = 4'h6;
   localparam logic [2:0] OP_PROG = 3'h1;
   localparam logic [2:0] OP_ERASE = 3'h2;
   localparam logic [2:0] OP_BLANK = 3'h3;
   localparam logic [2:0] OP_XWRITE = 3'h4;
   localparam logic [2:0] OP_XREAD = 3'h5;
   typedef enum logic [1:0] {MODE_DF_OFF, MODE_READ, MODE_CODE_PE, MODE_DATA_PE} mode_t;
endpackage

// file: flash_sequencer.sv
// Purpose: mode control, command sequencing and protection of flash
// Assumes: single clock, Wishbone classic slave, flash array outside
// Notes: all outputs come from the registered state struct
//
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module flash_sequencer (
   input wire logic sys_clk, // core clock, 20 MHz
   input wire logic resetn, // asynchronous reset, active low
   input wire logic cyc_i, // wishbone cycle
   input wire logic stb_i, // wishbone strobe
   input wire logic we_i, // wishbone write
   input wire logic [31:0] adr_i, // wishbone byte address
   input wire logic [3:0] sel_i, // wishbone byte enables
   input wire logic [31:0] dat_i, // wishbone write data
   output logic [31:0] dat_o, // wishbone read data
   output logic ack_o, // wishbone acknowledge
   input wire logic selfProg, // self-programming in single-chip mode
   input wire logic codeRdReq, // code flash read request
   output logic codeRdAck, // code flash read answer
   output logic dfReadEnable, // data flash may be read
   output logic cfReadEnable, // code flash may be read
   output logic flashReq, // flash operation request, level
   output logic [2:0] flashOp, // flash operation code
   output logic [19:0] flashAddr, // flash address
   output logic [31:0] flashWdata, // flash write data
   output logic [2:0] flashBytes, // bytes per program
   input wire logic flashDone, // flash operation done pulse
   input wire logic [31:0] flashRdata, // flash read data
   input wire logic flashBlank // range holds no data
);
   import flash_seq_pkg::*;

   // ****************************************************
   // state
   // ****************************************************
   typedef struct packed {
      mode_t mode; // sequencer mode
      logic dfEn; // dataflash_enable
      logic entCode; // codeflash_pe_entry
      logic entData; // dataflash_pe_entry
      logic [7:0] pmc; // pe_mode_control
      logic [19:0] addr; // command target
      logic [31:0] wdata; // program data
      logic [15:0] cfgLow; // config_word_low
      logic [15:0] cfgHigh; // config_word_high
      logic bootSel; // boot_area_select_flag
      logic [9:0] winStart; // window start block
      logic [9:0] winEnd; // window end block
      logic busy; // command running
      logic illegal; // illegal_command_flag
      logic blank; // blank check result
      logic [3:0] cmd; // running command
      logic [2:0] uidIdx; // identifier word counter
      logic [7:0][31:0] uid; // part_identifier_bytes
      logic ack; // bus answer
      logic [31:0] rdata; // bus read data
      logic fReq; // flash request
      logic [2:0] fOp; // flash op
      logic [19:0] fAddr; // flash address
      logic [31:0] fWdata; // flash data
      logic [2:0] fBytes; // flash byte count
      logic dfRdEn; // data flash readable
      logic cfRdEn; // code flash readable
      logic codeAck; // code read answer
   } state_t;

   state_t r; // registered state
   state_t next_r; // next state

   // ****************************************************
   // helper functions
   // ****************************************************
   // mode reached after a write to the three mode registers
   function automatic mode_t nextMode(mode_t cur, logic dfEn, logic ec,
                                      logic ed, logic [7:0] pmc);
      mode_t m;
      m = cur;
      if (ec && !ed && (pmc == PMC_CODE_A || pmc == PMC_CODE_B)) begin
         m = MODE_CODE_PE;
      end else if (ed && !ec && (pmc == PMC_DATA_A || pmc == PMC_DATA_B)) begin
         m = MODE_DATA_PE;
      end else if (!ec && !ed && pmc == PMC_READ && cur != MODE_DF_OFF) begin
         m = MODE_READ;
      end else if (cur == MODE_DF_OFF && dfEn) begin
         m = MODE_READ;
      end
      return m;
   endfunction

   // refusal check of a command at its start
   function automatic logic isIllegal(state_t s, logic [3:0] c, logic sp);
      logic code;
      logic [9:0] blk;
      logic bad;
      code = !s.addr[DF_BIT];
      blk = s.addr[DF_BIT:BLK_LSB];
      bad = 1'b0;
      if (c == CMD_PROG || c == CMD_ERASE || c == CMD_BLANK) begin
         if (code && s.mode != MODE_CODE_PE) begin
            bad = 1'b1;
         end else if (!code && s.mode != MODE_DATA_PE) begin
            bad = 1'b1;
         end
         // window applies to code area only, in self-programming
         if (c != CMD_BLANK && code && sp && s.winStart < s.winEnd &&
             (blk < s.winStart || blk >= s.winEnd)) begin
            bad = 1'b1;
         end
         // active start-up area is kept while the other is rewritten
         if (CODE_KBYTES >= 32 && c != CMD_BLANK && code &&
             blk[9:5] == 5'h00 && blk[4] == !s.bootSel) begin
            bad = 1'b1;
         end
      end else if (c == CMD_BOOT_PROG || c == CMD_WIN_PROG ||
                   c == CMD_UID_READ) begin
         bad = (s.mode != MODE_CODE_PE);
      end else begin
         bad = 1'b1; // unknown command
      end
      return bad;
   endfunction

   // byte-lane merge of a write
   function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] d,
                                         logic [3:0] sel);
      logic [31:0] v;
      v = old;
      for (int i = 0; i < 4; i++) begin
         if (sel[i]) begin
            v[8*i +: 8] = d[8*i +: 8];
         end
      end
      return v;
   endfunction

   // ****************************************************
   // bus decode
   // ****************************************************
   logic [29:0] idx; // word index
   logic wbReq; // new request not yet answered
   logic wbWr; // write taking effect this edge
   logic [31:0] wv; // merged write value
   assign idx = adr_i[31:2];
   assign wbReq = cyc_i && stb_i && !r.ack;
   assign wbWr = cyc_i && stb_i && we_i && r.ack;

   // ****************************************************
   // next-state logic
   // ****************************************************
   always_comb begin
      next_r = r;
      wv = 32'h0000_0000;
      // bus answer one cycle after request, dropped right after
      next_r.ack = wbReq;
      next_r.rdata = 32'h0000_0000;
      if (wbReq && !we_i) begin
         if (idx == IDX_DF_CTRL) begin
            next_r.rdata = {31'h0, r.dfEn};
         end else if (idx == IDX_ENTRY) begin
            next_r.rdata = {30'h0, r.entData, r.entCode};
         end else if (idx == IDX_PMC) begin
            next_r.rdata = {24'h0, r.pmc};
         end else if (idx == IDX_ADDR) begin
            next_r.rdata = {12'h0, r.addr};
         end else if (idx == IDX_WDATA) begin
            next_r.rdata = r.wdata;
         end else if (idx == IDX_CFG_LOW) begin
            next_r.rdata = {16'h0, r.cfgLow};
         end else if (idx == IDX_CFG_HIGH) begin
            next_r.rdata = {16'h0, r.cfgHigh};
         end else if (idx == IDX_STATUS) begin
            next_r.rdata = {26'h0, r.mode, 1'b0, r.blank, r.illegal, r.busy};
         end else if (idx[29:3] == IDX_UID[29:3]) begin
            next_r.rdata = r.uid[idx[2:0]];
         end else if (idx == IDX_BOOT_MON) begin
            next_r.rdata = {16'h0, 1'b0, BOOT_MON_HIGH[5:0], r.bootSel, 8'h00};
         end else if (idx == IDX_WSTART_MON) begin
            next_r.rdata = {22'h0, r.winStart};
         end else if (idx == IDX_WEND_MON) begin
            next_r.rdata = {22'h0, r.winEnd};
         end
      end
      // register writes; monitors and status ignore them
      if (wbWr) begin
         if (idx == IDX_DF_CTRL) begin
            wv = merge({31'h0, r.dfEn}, dat_i, sel_i);
            next_r.dfEn = wv[0];
         end else if (idx == IDX_ENTRY) begin
            wv = merge({30'h0, r.entData, r.entCode}, dat_i, sel_i);
            next_r.entCode = wv[0];
            next_r.entData = wv[1];
         end else if (idx == IDX_PMC) begin
            wv = merge({24'h0, r.pmc}, dat_i, sel_i);
            next_r.pmc = wv[7:0];
         end else if (idx == IDX_ADDR) begin
            wv = merge({12'h0, r.addr}, dat_i, sel_i);
            next_r.addr = wv[19:0];
         end else if (idx == IDX_WDATA) begin
            next_r.wdata = merge(r.wdata, dat_i, sel_i);
         end else if (idx == IDX_CFG_LOW) begin
            wv = merge({16'h0, r.cfgLow}, dat_i, sel_i);
            next_r.cfgLow = wv[15:0];
         end else if (idx == IDX_CFG_HIGH) begin
            wv = merge({16'h0, r.cfgHigh}, dat_i, sel_i);
            next_r.cfgHigh = wv[15:0];
         end
      end
      // mode follows only the three mode registers
      if (wbWr && (idx == IDX_DF_CTRL || idx == IDX_ENTRY || idx == IDX_PMC)) begin
         next_r.mode = nextMode(r.mode, next_r.dfEn, next_r.entCode,
                                next_r.entData, next_r.pmc);
      end
      // command start, ignored while busy
      if (wbWr && idx == IDX_CMD && sel_i[0] && !r.busy) begin
         next_r.cmd = dat_i[3:0];
         next_r.blank = 1'b0;
         next_r.illegal = isIllegal(r, dat_i[3:0], selfProg);
         if (!next_r.illegal) begin
            next_r.busy = 1'b1;
            next_r.fReq = 1'b1;
            next_r.fAddr = r.addr;
            next_r.fWdata = r.wdata;
            next_r.fBytes = r.addr[DF_BIT] ? BYTES_DATA : BYTES_CODE;
            next_r.uidIdx = 3'h0;
            case (dat_i[3:0])
               CMD_PROG: next_r.fOp = OP_PROG;
               CMD_ERASE: next_r.fOp = OP_ERASE;
               CMD_BLANK: next_r.fOp = OP_BLANK;
               CMD_BOOT_PROG, CMD_WIN_PROG: begin
                  next_r.fOp = OP_XWRITE;
                  next_r.fWdata = {r.cfgHigh, r.cfgLow};
               end
               default: begin
                  next_r.fOp = OP_XREAD;
                  next_r.fAddr = UID_ADDR;
               end
            endcase
         end
      end
      // flash answer ends or advances the command
      if (r.busy && r.fReq && flashDone) begin
         next_r.fReq = 1'b0;
         next_r.busy = 1'b0;
         case (r.cmd)
            CMD_BLANK: next_r.blank = flashBlank;
            CMD_BOOT_PROG: next_r.bootSel = r.cfgLow[BOOT_BIT];
            CMD_WIN_PROG: begin
               next_r.winStart = r.cfgLow[9:0];
               next_r.winEnd = r.cfgHigh[9:0];
            end
            CMD_UID_READ: begin
               next_r.uid[r.uidIdx] = flashRdata;
               if (r.uidIdx != UID_LAST) begin
                  next_r.uidIdx = r.uidIdx + 3'h1;
                  next_r.fAddr = r.fAddr + 20'h00004;
                  next_r.fReq = 1'b1;
                  next_r.busy = 1'b1;
               end
            end
            default: next_r.busy = 1'b0;
         endcase
      end
      // read paths follow the mode reached
      next_r.dfRdEn = (next_r.mode == MODE_READ || next_r.mode == MODE_CODE_PE);
      next_r.cfRdEn = (next_r.mode != MODE_CODE_PE);
      next_r.codeAck = codeRdReq && next_r.cfRdEn;
   end

   // ****************************************************
   // state register
   // ****************************************************
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         r <= '0;
         r.bootSel <= BLANK_BOOT;
         r.winStart <= BLANK_WIN;
         r.winEnd <= BLANK_WIN;
         r.cfRdEn <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   // ****************************************************
   // outputs
   // ****************************************************
   assign dat_o = r.rdata;
   assign ack_o = r.ack;
   assign codeRdAck = r.codeAck;
   assign dfReadEnable = r.dfRdEn;
   assign cfReadEnable = r.cfRdEn;
   assign flashReq = r.fReq;
   assign flashOp = r.fOp;
   assign flashAddr = r.fAddr;
   assign flashWdata = r.fWdata;
   assign flashBytes = r.fBytes;

   // ****************************************************
   // assertions
   // ****************************************************
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   a_bus_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
      else $error("ack missing one cycle after request");
   a_bus_ack_drop: assert property (ack_o |=> !ack_o)
      else $error("ack held two cycles");
   a_boot_mon_bits: assert property (cyc_i && stb_i && !we_i && !ack_o &&
      idx == IDX_BOOT_MON |=> dat_o[15:9] == 7'h3F && dat_o[7:0] == 8'h00)
      else $error("start-up monitor reserved bits wrong");
   a_boot_flag_load: assert property (r.busy && r.fReq && flashDone &&
      r.cmd == CMD_BOOT_PROG |=> r.bootSel == $past(r.cfgLow[8]))
      else $error("boot flag not loaded from low word");
   a_window_load: assert property (r.busy && r.fReq && flashDone &&
      r.cmd == CMD_WIN_PROG |=> r.winEnd == $past(r.cfgHigh[9:0]))
      else $error("window end not loaded from high word");
   a_monitor_steady: assert property (!(r.fReq && flashDone) |=>
      $stable(r.bootSel) && $stable(r.winStart))
      else $error("monitor changed without program command");
   a_code_read_one: assert property (codeRdReq && r.mode != MODE_CODE_PE &&
      !wbWr |=> codeRdAck)
      else $error("code read not answered in one cycle");
   a_code_pe_entry: assert property ($changed(r.mode) && r.mode == MODE_CODE_PE |->
      r.entCode && !r.entData && (r.pmc == 8'h82 || r.pmc == 8'hC2))
      else $error("code mode entered without proper settings");
   a_data_pe_entry: assert property ($changed(r.mode) && r.mode == MODE_DATA_PE |->
      r.entData && !r.entCode && (r.pmc == 8'h10 || r.pmc == 8'h50))
      else $error("data mode entered without proper settings");
   a_df_blocked: assert property (r.mode == MODE_DF_OFF |-> !dfReadEnable)
      else $error("data flash readable in disabled mode");
   a_window_refuse: assert property (wbWr && idx == IDX_CMD && !r.busy &&
      dat_i[3:0] == CMD_PROG && !r.addr[19] && selfProg &&
      r.winStart < r.winEnd && r.addr[19:10] >= r.winEnd |=> r.illegal && !r.busy)
      else $error("program outside window not refused");

   c_code_pe: cover property ($changed(r.mode) && r.mode == MODE_CODE_PE);
   c_uid_done: cover property (r.cmd == CMD_UID_READ && $fell(r.busy));
   c_illegal: cover property ($rose(r.illegal));
   c_window_prog: cover property (r.cmd == CMD_WIN_PROG && $fell(r.busy));

endmodule // flash_sequencer
`default_nettype wire

// file: flash_array_model.sv
// Purpose: behavioural flash array on the far side of the sequencer
// Assumes: request level held until the done pulse is seen
// Notes: data and blank result are valid only with the done pulse
`timescale 1ns/1ps
`default_nettype none
module flash_array_model (
   input wire logic sys_clk, // core clock
   input wire logic resetn, // asynchronous reset, active low
   input wire logic flashReq, // operation request level
   input wire logic [19:0] flashAddr, // operation address
   output logic flashDone, // one-cycle completion pulse
   output logic [31:0] flashRdata, // read data
   output logic flashBlank // blank result
);
   logic [2:0] waitCnt; // cycles left before done
   logic [31:0] junk; // changing pattern shown outside done
   // answer each request after a random wait of 0..5 cycles
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         flashDone <= 1'b0;
         waitCnt <= 3'h0;
         junk <= 32'h0;
      end else begin
         junk <= junk + 32'h9E3779B9;
         flashDone <= 1'b0;
         if (flashReq && !flashDone) begin
            if (waitCnt == 3'h0) begin
               flashDone <= 1'b1;
               waitCnt <= 3'($urandom % 6);
            end else begin
               waitCnt <= waitCnt - 3'h1;
            end
         end
      end
   end
   // identifier words depend on the address; no stale value when idle
   assign flashRdata = flashDone ? {12'hC3A, flashAddr} : junk;
   assign flashBlank = flashDone ? ^flashAddr : junk[0];
endmodule // flash_array_model
`default_nettype wire

// file: test_flash_sequencer.sv
// Purpose: self-checking bench of the flash programming sequencer
// Assumes: array model answers requests on the far side
// Notes: fixed seed, registers reached over classic wishbone
`timescale 1ns/1ps
`default_nettype none
module test_flash_sequencer;
   import flash_seq_pkg::*;
   logic sys_clk = 1'b0; // core clock
   logic resetn = 1'b0; // reset, active low
   logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0; // bus controls
   logic [31:0] wbAdr = 32'h0, wbDat = 32'h0; // address and write data
   logic selfProg = 1'b0, codeRdReq = 1'b0; // side inputs
   logic [31:0] datO, flashWdata, flashRdata, lastWdata, rd, d;
   logic ack, codeRdAck, dfReadEnable, cfReadEnable, flashReq, flashDone, flashBlank;
   logic [2:0] flashOp, flashBytes, lastOp, lastBytes;
   logic [19:0] flashAddr, lastAddr, a;
   logic [7:0] pmcTab [4] = '{PMC_CODE_A, PMC_CODE_B, PMC_DATA_A, PMC_DATA_B};
   logic [9:0] blkTab [5] = '{10'd60, 10'd45, 10'd60, 10'd50, 10'd40};
   logic [4:0] spBits = 5'b11011; // self-programming level per window case
   int reqCount = 0, k, bad_count = 0, checks_done = 0;
   always #25 sys_clk = ~sys_clk;
   flash_sequencer dut_u (.sys_clk(sys_clk), .resetn(resetn), .cyc_i(wbCyc), .stb_i(wbStb),
      .we_i(wbWe), .adr_i(wbAdr), .sel_i(4'hF), .dat_i(wbDat), .dat_o(datO), .ack_o(ack),
      .selfProg(selfProg), .codeRdReq(codeRdReq), .codeRdAck(codeRdAck),
      .dfReadEnable(dfReadEnable), .cfReadEnable(cfReadEnable), .flashReq(flashReq),
      .flashOp(flashOp), .flashAddr(flashAddr), .flashWdata(flashWdata),
      .flashBytes(flashBytes), .flashDone(flashDone), .flashRdata(flashRdata),
      .flashBlank(flashBlank));
   flash_array_model far_u (.sys_clk(sys_clk), .resetn(resetn), .flashReq(flashReq),
      .flashAddr(flashAddr), .flashDone(flashDone), .flashRdata(flashRdata),
      .flashBlank(flashBlank));
   // record each operation as the array completes it
   always @(posedge sys_clk) begin
      if (flashReq && flashDone) begin
         reqCount <= reqCount + 1;
         lastOp <= flashOp;
         lastAddr <= flashAddr;
         lastWdata <= flashWdata;
         lastBytes <= flashBytes;
      end
   end
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // expected start-up monitor: bit 15 zero, bits 14..9 one, flag at bit 8
   function automatic logic [31:0] expBootMon(input logic flag);
      return {16'h0, 7'h3F, flag, 8'h00};
   endfunction
   // expected refusal of a code program under the window [40,50)
   function automatic logic expWinBad(input logic sp, input logic [9:0] blk);
      return sp && (blk < 10'd40 || blk >= 10'd50);
   endfunction
   // one classic cycle; held until ack is sampled high
   task automatic wb(input logic wr, input logic [29:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge sys_clk);
      wbCyc <= 1'b1;
      wbStb <= 1'b1;
      wbWe <= wr;
      wbAdr <= {idx, 2'b00};
      wbDat <= wd;
      do begin
         @(posedge sys_clk);
         n++;
      end while (ack !== 1'b1 && n < 40);
      if (n >= 40) bad_count++;
      rd = datO;
      wbCyc <= 1'b0;
      wbStb <= 1'b0;
   endtask
   task automatic rdChk(input logic [29:0] idx, input logic [31:0] exp);
      wb(1'b0, idx, 32'h0);
      chk(rd, exp);
   endtask
   // mode, blank and illegal bits with busy clear
   task automatic chkStat(input logic [1:0] m, input logic b, input logic il);
      wb(1'b0, IDX_STATUS, 32'h0);
      chk(rd & 32'h37, {26'h0, m, 1'b0, b, il, 1'b0});
   endtask
   // start a command and poll busy until it clears
   task automatic cmd(input logic [3:0] c, input logic [19:0] ad);
      int n;
      n = 0;
      wb(1'b1, IDX_ADDR, {12'h0, ad});
      wb(1'b1, IDX_CMD, {28'h0, c});
      do begin
         wb(1'b0, IDX_STATUS, 32'h0);
         n++;
      end while (rd[0] !== 1'b0 && n < 40);
      if (n >= 40) bad_count++;
   endtask
   initial begin
      repeat (20000) @(posedge sys_clk);
      bad_count++;
      results();
   end
   initial begin
      void'($urandom(64949));
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      chk({31'h0, dfReadEnable}, 32'h0);
      chkStat(2'h0, 1'b0, 1'b0);
      wb(1'b1, IDX_BOOT_MON, 32'h0);
      rdChk(IDX_BOOT_MON, expBootMon(1'b1));
      rdChk(IDX_WSTART_MON, 32'h3FF);
      wb(1'b1, IDX_WEND_MON, 32'h0);
      rdChk(IDX_WEND_MON, 32'h3FF);
      rdChk(IDX_UID, 32'h0);
      rdChk(30'h100, 32'h0);
      codeRdReq <= 1'b1;
      repeat (2) @(posedge sys_clk);
      chk({31'h0, codeRdAck}, 32'h1);
      codeRdReq <= 1'b0;
      $display("test reset done");
      wb(1'b1, IDX_DF_CTRL, 32'h1);
      chkStat(2'h1, 1'b0, 1'b0);
      chk({31'h0, dfReadEnable}, 32'h1);
      for (int i = 0; i < 4; i++) begin
         wb(1'b1, IDX_ENTRY, (i < 2) ? 32'h1 : 32'h2);
         wb(1'b1, IDX_PMC, {24'h0, pmcTab[i]});
         chkStat((i < 2) ? 2'h2 : 2'h3, 1'b0, 1'b0);
         chk({30'h0, dfReadEnable, cfReadEnable}, (i < 2) ? 32'h2 : 32'h1);
         if (i == 3) begin
            cmd(CMD_PROG, 20'h80000 | 20'($urandom % 1024));
            chk({29'h0, lastBytes}, 32'h1);
         end
         wb(1'b1, IDX_ENTRY, 32'h0);
         wb(1'b1, IDX_PMC, {24'h0, PMC_READ});
         chkStat(2'h1, 1'b0, 1'b0);
      end
      $display("test modes done");
      wb(1'b1, IDX_ENTRY, 32'h1);
      wb(1'b1, IDX_PMC, {24'h0, PMC_CODE_A});
      for (int i = 0; i < 8; i++) begin
         a = {10'(16 + $urandom % 400), 8'($urandom), 2'b00};
         d = $urandom;
         wb(1'b1, IDX_WDATA, d);
         cmd(i[0] ? CMD_ERASE : CMD_PROG, a);
         chk({9'h0, lastOp, lastAddr}, {9'h0, i[0] ? OP_ERASE : OP_PROG, a});
         if (!i[0]) chk(lastWdata, d);
         if (!i[0]) chk({29'h0, lastBytes}, 32'h4);
      end
      a = {10'(20 + $urandom % 300), 10'h0};
      cmd(CMD_BLANK, a);
      chkStat(2'h2, ^a, 1'b0);
      k = reqCount;
      cmd(CMD_PROG, 20'h01400);
      chkStat(2'h2, 1'b0, 1'b1);
      chk(32'(reqCount - k), 32'h0);
      cmd(4'hF, 20'h0);
      chkStat(2'h2, 1'b0, 1'b1);
      $display("test commands done");
      wb(1'b1, IDX_CFG_LOW, 32'd40);
      wb(1'b1, IDX_CFG_HIGH, 32'd50);
      cmd(CMD_WIN_PROG, 20'h0);
      rdChk(IDX_WSTART_MON, 32'd40);
      rdChk(IDX_WEND_MON, 32'd50);
      chk(lastWdata, {16'd50, 16'd40});
      for (int i = 0; i < 5; i++) begin
         selfProg <= spBits[i];
         cmd(CMD_PROG, {blkTab[i], 10'h0});
         chkStat(2'h2, 1'b0, expWinBad(spBits[i], blkTab[i]));
      end
      // data flash lies outside the window even in self-programming
      wb(1'b1, IDX_ENTRY, 32'h2);
      wb(1'b1, IDX_PMC, {24'h0, PMC_DATA_A});
      cmd(CMD_PROG, {1'b1, 9'd60, 10'h0});
      chkStat(2'h3, 1'b0, 1'b0);
      wb(1'b1, IDX_ENTRY, 32'h1);
      wb(1'b1, IDX_PMC, {24'h0, PMC_CODE_A});
      selfProg <= 1'b0;
      wb(1'b1, IDX_CFG_LOW, 32'h0);
      cmd(CMD_BOOT_PROG, 20'h0);
      rdChk(IDX_BOOT_MON, expBootMon(1'b0));
      rdChk(IDX_WSTART_MON, 32'd40);
      cmd(CMD_PROG, 20'h05000);
      chkStat(2'h2, 1'b0, 1'b1);
      cmd(CMD_PROG, 20'h01400);
      chkStat(2'h2, 1'b0, 1'b0);
      $display("test protection done");
      k = reqCount;
      cmd(CMD_UID_READ, 20'h0);
      chk(32'(reqCount - k), 32'h8);
      for (int i = 0; i < 8; i++) begin
         rdChk(IDX_UID + 30'(i), {12'hC3A, UID_ADDR + 20'(4 * i)});
      end
      $display("test identifier done");
      results();
   end
endmodule // test_flash_sequencer
`default_nettype wire
